// *** hw/fp_xfer_pkg.sv ***
// constants, encodings and register map of the fp operand transfer unit
// assumes a 32-bit apb slave port and an 80-bit operand path
package fp_xfer_pkg;

  localparam int EXT_W = 80;

  // extended operand fields
  localparam logic [14:0] EXP_MAX  = 15'h7fff;
  localparam logic [14:0] EXP_ZERO = 15'h0000;
  localparam logic signed [16:0] EXT_BIAS = 17'sh3fff;
  localparam logic signed [16:0] F32_BIAS = 17'sh007f;
  localparam logic signed [16:0] F64_BIAS = 17'sh03ff;
  localparam logic signed [16:0] F32_DEN_EXP = -17'sh007e;
  localparam logic signed [16:0] F64_DEN_EXP = -17'sh03fe;
  localparam logic signed [16:0] INT_EXP = 17'sh003f;

  // escape opcode class bounds
  localparam logic [7:0] ESC_FIRST = 8'hd8;
  localparam logic [7:0] ESC_LAST  = 8'hdf;
  localparam logic [7:0] OPC_D9 = 8'hd9;
  localparam logic [7:0] OPC_DA = 8'hda;
  localparam logic [7:0] OPC_DB = 8'hdb;
  localparam logic [7:0] OPC_DD = 8'hdd;
  localparam logic [7:0] OPC_DF = 8'hdf;

  // special encodings
  localparam logic [79:0] EXT_INDEF = 80'hffff_c000_0000_0000_0000;
  localparam logic [79:0] BCD_INDEF = 80'hffff_c000_0000_0000_0000;
  localparam logic [63:0] BCD_MAX_MAG = 64'h0de0_b6b3_a763_ffff;
  localparam logic [63:0] TEN = 64'h0000_0000_0000_000a;
  localparam logic [7:0]  F32_EXP_MAX = 8'hff;
  localparam logic [10:0] F64_EXP_MAX = 11'h7ff;

  // register map, byte addresses
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] STATUS_OFS  = 12'h004;
  localparam logic [11:0] TAG_OFS     = 12'h008;
  localparam logic [11:0] FEATURE_OFS = 12'h00c;
  localparam int CTRL_INV_MASK = 0;
  localparam int CTRL_DEN_MASK = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int STAT_INV = 0;
  localparam int STAT_DEN = 1;
  localparam int STAT_TOP_LSB = 8;
  localparam int FEAT_CMOV = 0;

  typedef enum logic [2:0] {
    FMT_F32 = 3'b000, FMT_F64 = 3'b001, FMT_F80 = 3'b010,
    FMT_I16 = 3'b011, FMT_I32 = 3'b100, FMT_I64 = 3'b101,
    FMT_BCD = 3'b110
  } fmt_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_LOAD_MEM = 3'b001, OP_LOAD_REG = 3'b010,
    OP_STORE_MEM = 3'b011, OP_STORE_REG = 3'b100, OP_XCH = 3'b101,
    OP_CMOV = 3'b110
  } op_e;

endpackage : fp_xfer_pkg

// *** hw/fp_operand_classifier.sv ***
// classifies one extended-precision operand
// assumes a plain 80-bit value, sign in bit 79, integer bit in bit 63
`timescale 1ns/100ps
`default_nettype none
module fp_operand_classifier
  import fp_xfer_pkg::*;
(
  input  wire logic [79:0] value,
  output logic             unsupported,
  output logic             pseudo_denormal
);
  logic [14:0] exp_f;
  logic        int_bit;
  logic        frac_nz;
  logic        pseudo_nan;
  logic        pseudo_inf;
  logic        unnormal;

  assign exp_f   = value[78:64];
  assign int_bit = value[63];
  assign frac_nz = |value[62:0];

  assign pseudo_nan = (exp_f == EXP_MAX) && !int_bit && frac_nz;
  assign pseudo_inf = (exp_f == EXP_MAX) && !int_bit && !frac_nz;
  assign unnormal   = (exp_f != EXP_MAX) && (exp_f != EXP_ZERO) && !int_bit;
  assign unsupported = pseudo_nan || pseudo_inf || unnormal;
  assign pseudo_denormal = (exp_f == EXP_ZERO) && int_bit;
endmodule : fp_operand_classifier
`default_nettype wire

// *** hw/fp_operand_transfer_unit.sv ***
// floating-point stack data transfer unit with apb control registers
// assumes decoder and memory path on pclk, one instruction per beat
// Functional notes
// - pseudo-NaN, pseudo-infinity, unnormal operands raise invalid, never used as numbers
// - classify by max exponent, integer bit and fraction; 15/63-bit fields
// - zero exponent with integer bit set is denormal; raise denormal
// - never produce pseudo-denormal results; accept them only as inputs
// - escape opcodes are first bytes d8 through df inclusive
// - operands only from stack or memory, no immediates
// - register operands are offsets from the stack top
// - floating load converts and pushes memory or stack register value
// - integer and packed decimal loads convert and push
// - floating and integer store write converted top, no pop
// - store-and-pop forms write converted top, then pop
// - pop tags top empty and increments stack pointer; a store-pop to register offset 0 leaves that tag set
// - floating store-pop may target a stack register
// - exchange swaps selected register with stack top
// - conditional move copies selected register to top when condition holds
// - conditions from carry, zero, parity flags per encoding
// - feature bit reports conditional move support
// - masked invalid integer store writes integer indefinite
// - memory operands least significant byte first
`timescale 1ns/100ps
`default_nettype none
module fp_operand_transfer_unit
  import fp_xfer_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ins_valid,
  input  wire logic [7:0]  ins_opcode,
  input  wire logic [7:0]  ins_modrm,
  input  wire logic [79:0] ins_operand,
  input  wire logic        carry_status_flag,
  input  wire logic        zero_status_flag,
  input  wire logic        parity_status_flag,
  output logic             ins_ready,
  output logic             ins_done,
  output logic             ins_reject,
  output logic             exc_invalid,
  output logic             exc_denormal,
  output logic             st_valid,
  output logic      [79:0] st_data,
  output logic      [3:0]  st_size
);
  logic [79:0] stk_r [8];
  logic [7:0]  tag_r;
  logic [2:0]  top_r;
  logic [1:0]  ctrl_r;
  logic [1:0]  sticky_r;

  function automatic logic [79:0] norm(input logic s,
      input logic signed [16:0] e, input logic [63:0] m);
    logic [63:0] mm;
    logic signed [16:0] ee;
    logic [16:0] b;
    mm = m;
    ee = e;
    for (int i = 0; i < 64; i++) begin
      if (!mm[63]) begin
        mm = mm << 1;
        ee = ee - 17'sh0001;
      end
    end
    b = 17'(ee + EXT_BIAS);
    norm = (m == 64'h0) ? {s, 79'h0} : {s, b[14:0], mm};
  endfunction : norm

  // truncating conversion, returns {bad, signed value}
  function automatic logic [64:0] ext_to_int(input logic [79:0] v,
      input logic [6:0] w);
    logic signed [16:0] e;
    logic [63:0] mag;
    logic bad;
    e = $signed({2'b00, v[78:64]}) - EXT_BIAS;
    bad = (v[78:64] == EXP_MAX) || (e > $signed({10'h000, w}) - 17'sh0002);
    mag = (e < 0 || !v[63] || bad) ? 64'h0 : v[63:0] >> (6'h3f - e[5:0]);
    ext_to_int = {bad, v[79] ? 64'(-mag) : mag};
  endfunction : ext_to_int

  function automatic logic [3:0] fmt_bytes(input fmt_e f);
    unique case (f)
      FMT_F32, FMT_I32: fmt_bytes = 4'h4;
      FMT_F64, FMT_I64: fmt_bytes = 4'h8;
      FMT_I16:          fmt_bytes = 4'h2;
      default:          fmt_bytes = 4'ha;
    endcase
  endfunction : fmt_bytes

  // decode
  op_e        op;
  fmt_e       fmt;
  logic       pop;
  logic [2:0] cond;
  logic       is_esc;
  logic       mod3;
  logic [2:0] rf;
  assign mod3 = (ins_modrm[7:6] == 2'b11);
  assign rf   = ins_modrm[5:3];
  assign is_esc = (ins_opcode >= ESC_FIRST) && (ins_opcode <= ESC_LAST);

  // no immediate forms exist in this table
  always_comb begin
    op = OP_NONE;
    fmt = FMT_F80;
    pop = 1'b0;
    cond = {ins_opcode[0], rf[1:0]};
    unique case (ins_opcode)
      OPC_D9: begin
        if (mod3) begin
          if (rf == 3'h0) op = OP_LOAD_REG;
          if (rf == 3'h1) op = OP_XCH;
        end else begin
          fmt = FMT_F32;
          if (rf == 3'h0) op = OP_LOAD_MEM;
          if (rf == 3'h2 || rf == 3'h3) op = OP_STORE_MEM;
          pop = (rf == 3'h3);
        end
      end
      OPC_DA: if (mod3 && !rf[2]) op = OP_CMOV;
      OPC_DB: begin
        if (mod3) begin
          if (!rf[2]) op = OP_CMOV;
        end else begin
          fmt = (rf[2]) ? FMT_F80 : FMT_I32;
          if (rf == 3'h0 || rf == 3'h5) op = OP_LOAD_MEM;
          if (rf == 3'h2 || rf == 3'h3 || rf == 3'h7) op = OP_STORE_MEM;
          pop = (rf == 3'h3) || (rf == 3'h7);
        end
      end
      OPC_DD: begin
        fmt = FMT_F64;
        pop = (rf == 3'h3);
        if (mod3 && (rf == 3'h2 || rf == 3'h3)) op = OP_STORE_REG;
        if (!mod3 && rf == 3'h0) op = OP_LOAD_MEM;
        if (!mod3 && (rf == 3'h2 || rf == 3'h3)) op = OP_STORE_MEM;
      end
      OPC_DF: begin
        if (!mod3) begin
          fmt = (rf == 3'h4 || rf == 3'h6) ? FMT_BCD :
                (rf == 3'h5 || rf == 3'h7) ? FMT_I64 : FMT_I16;
          if (rf == 3'h0 || rf == 3'h4 || rf == 3'h5) op = OP_LOAD_MEM;
          if (rf == 3'h2 || rf == 3'h3 || rf[2:1] == 2'b11) op = OP_STORE_MEM;
          pop = (rf == 3'h3) || (rf[2:1] == 2'b11);
        end
      end
      default: op = OP_NONE;
    endcase
  end

  logic [2:0]  sel_idx;
  logic [79:0] top_val;
  logic [79:0] sel_val;
  assign sel_idx = top_r + ins_modrm[2:0];
  assign top_val = stk_r[top_r];
  assign sel_val = stk_r[sel_idx];

  logic cond_base;
  logic cond_true;
  always_comb begin
    unique case (cond[1:0])
      2'b00: cond_base = carry_status_flag;
      2'b01: cond_base = zero_status_flag;
      2'b10: cond_base = carry_status_flag | zero_status_flag;
      2'b11: cond_base = parity_status_flag;
    endcase
  end
  assign cond_true = cond[2] ^ cond_base;

  logic [79:0] cls_in;
  logic        cls_unsup;
  logic        cls_pden;
  // narrow memory formats hold no extended encoding, upper bits ignored
  assign cls_in = (op == OP_LOAD_MEM && fmt != FMT_F80) ? 80'h0 :
                  (op == OP_LOAD_MEM) ? ins_operand :
                  (op == OP_LOAD_REG) ? sel_val : top_val;
  fp_operand_classifier u_cls (
    .value           (cls_in),
    .unsupported     (cls_unsup),
    .pseudo_denormal (cls_pden)
  );

  // load conversion to extended
  logic [79:0] ld_val;
  logic        ld_den;
  logic [63:0] ld_int;
  logic [63:0] ld_bin;
  always_comb begin
    ld_val = ins_operand;
    ld_den = 1'b0;
    ld_int = 64'h0;
    ld_bin = 64'h0;
    unique case (fmt)
      FMT_F32: begin
        if (ins_operand[30:23] == F32_EXP_MAX)
          ld_val = {ins_operand[31], EXP_MAX, 1'b1, ins_operand[22:0],
                    40'h0};
        else if (ins_operand[30:23] == 8'h00) begin
          ld_den = |ins_operand[22:0];
          ld_val = norm(ins_operand[31], F32_DEN_EXP,
                        {1'b0, ins_operand[22:0], 40'h0});
        end else
          ld_val = norm(ins_operand[31],
              $signed({9'h000, ins_operand[30:23]}) - F32_BIAS,
              {1'b1, ins_operand[22:0], 40'h0});
      end
      FMT_F64: begin
        if (ins_operand[62:52] == F64_EXP_MAX)
          ld_val = {ins_operand[63], EXP_MAX, 1'b1, ins_operand[51:0],
                    11'h0};
        else if (ins_operand[62:52] == 11'h000) begin
          ld_den = |ins_operand[51:0];
          ld_val = norm(ins_operand[63], F64_DEN_EXP,
                        {1'b0, ins_operand[51:0], 11'h0});
        end else
          ld_val = norm(ins_operand[63],
              $signed({6'h00, ins_operand[62:52]}) - F64_BIAS,
              {1'b1, ins_operand[51:0], 11'h0});
      end
      FMT_I16, FMT_I32, FMT_I64: begin
        ld_int = (fmt == FMT_I16) ? {{48{ins_operand[15]}}, ins_operand[15:0]}
               : (fmt == FMT_I32) ? {{32{ins_operand[31]}}, ins_operand[31:0]}
               : ins_operand[63:0];
        ld_val = norm(ld_int[63], INT_EXP, ld_int[63] ? 64'(-ld_int) : ld_int);
      end
      FMT_BCD: begin
        for (int k = 17; k >= 0; k--)
          ld_bin = (ld_bin * TEN) + {60'h0, ins_operand[k*4 +: 4]};
        ld_val = norm(ins_operand[79], INT_EXP, ld_bin);
      end
      default: begin
        // pseudo-denormal rewritten with exponent 0001, integer bit and fraction kept
        ld_den = cls_pden;
        if (cls_pden) ld_val = {ins_operand[79], 15'h0001, ins_operand[63:0]};
      end
    endcase
  end

  // store conversion from stack top
  logic [79:0] src;
  logic [79:0] st_val;
  logic        st_bad;
  logic [64:0] cvt;
  logic [71:0] bcd;
  logic signed [16:0] se;
  logic [63:0] mag;
  always_comb begin
    src = cls_unsup ? EXT_INDEF : top_val;
    se = $signed({2'b00, src[78:64]}) - EXT_BIAS;
    st_val = src;
    st_bad = 1'b0;
    cvt = 65'h0;
    bcd = 72'h0;
    mag = 64'h0;
    unique case (fmt)
      FMT_F32: begin
        if (src[78:64] == EXP_MAX)
          st_val = {48'h0, src[79], F32_EXP_MAX, src[62:40]};
        else if (!src[63] || se < -17'sh007e)
          st_val = {48'h0, src[79], 31'h0};
        else if (se > 17'sh007f)
          st_val = {48'h0, src[79], F32_EXP_MAX, 23'h0};
        else
          st_val = {48'h0, src[79], 8'(se + F32_BIAS), src[62:40]};
      end
      FMT_F64: begin
        if (src[78:64] == EXP_MAX)
          st_val = {16'h0, src[79], F64_EXP_MAX, src[62:11]};
        else if (!src[63] || se < -17'sh03fe)
          st_val = {16'h0, src[79], 63'h0};
        else if (se > 17'sh03ff)
          st_val = {16'h0, src[79], F64_EXP_MAX, 52'h0};
        else
          st_val = {16'h0, src[79], 11'(se + F64_BIAS), src[62:11]};
      end
      FMT_I16, FMT_I32, FMT_I64: begin
        cvt = ext_to_int(src, (fmt == FMT_I16) ? 7'h10 :
                              (fmt == FMT_I32) ? 7'h20 : 7'h40);
        st_bad = cvt[64];
        if (fmt == FMT_I16)
          st_val = {64'h0, st_bad ? 16'h8000 : cvt[15:0]};
        else if (fmt == FMT_I32)
          st_val = {48'h0, st_bad ? 32'h8000_0000 : cvt[31:0]};
        else
          st_val = {16'h0, st_bad ? 64'h8000_0000_0000_0000 : cvt[63:0]};
      end
      FMT_BCD: begin
        cvt = ext_to_int(src, 7'h40);
        mag = src[79] ? 64'(-cvt[63:0]) : cvt[63:0];
        st_bad = cvt[64] || (mag > BCD_MAX_MAG);
        for (int i = 63; i >= 0; i--) begin
          for (int k = 0; k < 18; k++)
            if (bcd[k*4 +: 4] > 4'h4) bcd[k*4 +: 4] = bcd[k*4 +: 4] + 4'h3;
          bcd = {bcd[70:0], mag[i]};
        end
        st_val = st_bad ? BCD_INDEF : {src[79], 7'h00, bcd};
      end
      default: st_val = src;
    endcase
  end

  logic fire;
  logic inv_ev;
  logic den_ev;
  logic good;
  assign fire = ins_valid && ins_ready;
  assign inv_ev = fire && is_esc && (op != OP_NONE) && (op != OP_XCH)
                  && (op != OP_CMOV)
                  && (cls_unsup || (op == OP_STORE_MEM && st_bad));
  assign den_ev = fire && (op == OP_LOAD_MEM || op == OP_LOAD_REG)
                  && (ld_den || cls_pden);
  // unmasked invalid leaves stack and memory untouched
  assign good = !inv_ev || ctrl_r[CTRL_INV_MASK];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_r <= 3'h0;
      tag_r <= 8'h00;
      for (int i = 0; i < 8; i++) stk_r[i] <= 80'h0;
    end else if (fire && is_esc && good) begin
      unique case (op)
        OP_LOAD_MEM, OP_LOAD_REG: begin
          top_r <= top_r - 3'h1;
          tag_r[top_r - 3'h1] <= 1'b1;
          stk_r[top_r - 3'h1] <= cls_unsup ? EXT_INDEF :
              (op == OP_LOAD_MEM) ? ld_val :
              (cls_pden ? {sel_val[79], 15'h0001, sel_val[63:0]} : sel_val);
        end
        OP_STORE_MEM, OP_STORE_REG: begin
          if (op == OP_STORE_REG) begin
            stk_r[sel_idx] <= top_val;
            tag_r[sel_idx] <= 1'b1;
          end
          if (pop && !(op == OP_STORE_REG && sel_idx == top_r)) begin
            tag_r[top_r] <= 1'b0;
          end
          if (pop) top_r <= top_r + 3'h1;
        end
        OP_XCH: begin
          stk_r[sel_idx] <= top_val;
          stk_r[top_r]   <= sel_val;
          tag_r[sel_idx] <= tag_r[top_r];
          tag_r[top_r]   <= tag_r[sel_idx];
        end
        OP_CMOV: if (cond_true) begin
          stk_r[top_r] <= sel_val;
          tag_r[top_r] <= tag_r[sel_idx];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ins_ready    <= 1'b0;
      ins_done     <= 1'b0;
      ins_reject   <= 1'b0;
      exc_invalid  <= 1'b0;
      exc_denormal <= 1'b0;
      st_valid     <= 1'b0;
      st_data      <= 80'h0;
      st_size      <= 4'h0;
    end else begin
      ins_ready    <= 1'b1;
      ins_done     <= fire;
      ins_reject   <= fire && (!is_esc || op == OP_NONE);
      exc_invalid  <= inv_ev;
      exc_denormal <= den_ev;
      st_valid     <= fire && is_esc && (op == OP_STORE_MEM) && good;
      if (fire && is_esc && op == OP_STORE_MEM && good) begin
        // byte 0 in bits 7:0, ascending
        st_data <= st_val;
        st_size <= fmt_bytes(fmt);
      end
    end
  end

  // apb slave, one wait-free access phase
  logic acc;
  logic hit;
  assign acc = psel && penable && pready;
  assign hit = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) ||
               (paddr == TAG_OFS) || (paddr == FEATURE_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          CTRL_OFS:    prdata <= {30'h0, ctrl_r};
          STATUS_OFS:  prdata <= {21'h0, top_r, 6'h0, sticky_r};
          TAG_OFS:     prdata <= {24'h0, tag_r};
          FEATURE_OFS: prdata <= 32'h0000_0001 << FEAT_CMOV;
          default:     prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_r <= CTRL_RESET;
    else if (acc && pwrite && paddr == CTRL_OFS) ctrl_r <= pwdata[1:0];
  end

  // write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sticky_r <= 2'b00;
    else begin
      sticky_r[STAT_INV] <= inv_ev || (sticky_r[STAT_INV] &&
          !(acc && pwrite && paddr == STATUS_OFS && pwdata[STAT_INV]));
      sticky_r[STAT_DEN] <= den_ev || (sticky_r[STAT_DEN] &&
          !(acc && pwrite && paddr == STATUS_OFS && pwdata[STAT_DEN]));
    end
  end
endmodule : fp_operand_transfer_unit
`default_nettype wire

// *** dv/fp_xfer_assertions.sv ***
// port checker for the fp operand transfer unit
// assumes it is bound to the top module, one pclk domain
`timescale 1ns/100ps
`default_nettype none
module fp_xfer_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ins_valid,
  input wire logic [7:0]  ins_opcode,
  input wire logic        ins_ready,
  input wire logic        ins_done,
  input wire logic        ins_reject,
  input wire logic        exc_invalid,
  input wire logic        st_valid,
  input wire logic [79:0] st_data,
  input wire logic [3:0]  st_size
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic take = ins_valid && ins_ready;

  done_after_take_a: assert property (take |=> ins_done)
    else $error("taken instruction not answered");
  no_stray_done_a: assert property (!take |=> !ins_done)
    else $error("answer without instruction");
  esc_range_a: assert property (
    take && (ins_opcode < 8'hd8 || ins_opcode > 8'hdf)
    |=> ins_reject && !st_valid)
    else $error("non escape byte accepted");
  pulse_with_done_a: assert property (
    (ins_reject || exc_invalid || st_valid) |-> ins_done)
    else $error("pulse outside answer cycle");
  store_hold_a: assert property (st_valid || $stable(st_data))
    else $error("store data moved without store");
  store_size_a: assert property (
    st_valid |-> st_size inside {4'h2, 4'h4, 4'h8, 4'ha})
    else $error("illegal store size");
  no_pseudo_den_a: assert property (
    st_valid && st_size == 4'ha && $past(ins_opcode) == 8'hdb
    |-> !(st_data[78:64] == 15'h0000 && st_data[63]))
    else $error("pseudo denormal produced");
  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
  unmapped_err_a: assert property (
    psel && penable && pready && paddr > 12'h00c |-> pslverr)
    else $error("unmapped access not refused");

  cover property (take && ins_opcode inside {8'hda, 8'hdb});
  cover property (exc_invalid && st_valid);
  cover property (pready && pslverr);
endmodule : fp_xfer_assertions

bind fp_operand_transfer_unit fp_xfer_assertions u_fp_xfer_assertions (
  .pclk, .presetn, .paddr, .psel, .penable, .pready, .pslverr, .ins_valid,
  .ins_opcode, .ins_ready, .ins_done, .ins_reject, .exc_invalid, .st_valid,
  .st_data, .st_size);
`default_nettype wire

// *** dv/fp_xfer_partner.sv ***
// decoder and memory operand path model for the instruction port
// assumes the unit takes an instruction when valid meets ready
`timescale 1ns/100ps
`default_nettype none
module fp_xfer_partner (
  input  wire logic  pclk,
  input  wire logic  ins_ready,
  output logic       ins_valid,
  output logic [7:0] ins_opcode,
  output logic [7:0] ins_modrm,
  output logic [79:0] ins_operand,
  output logic       carry_status_flag,
  output logic       zero_status_flag,
  output logic       parity_status_flag
);
  initial begin
    ins_valid = 1'b0;
    ins_opcode = 8'h00;
    ins_modrm = 8'h00;
    ins_operand = '0;
    {parity_status_flag, zero_status_flag, carry_status_flag} = 3'h0;
  end

  // returns inside the cycle that carries the answer
  task automatic issue(input logic [7:0] op, rm, input logic [79:0] opd,
                       input logic [2:0] flg);
    int n;
    @(posedge pclk);
    ins_valid <= 1'b1;
    ins_opcode <= op;
    ins_modrm <= rm;
    ins_operand <= opd;
    {parity_status_flag, zero_status_flag, carry_status_flag} <= flg;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!ins_ready && n < 8);
    ins_valid <= 1'b0;
    // released operand and flag lines must not look like the last value
    ins_operand <= ~opd;
    {parity_status_flag, zero_status_flag, carry_status_flag} <= ~flg;
    @(negedge pclk);
  endtask : issue
endmodule : fp_xfer_partner
`default_nettype wire

// *** dv/test_fp_operand_transfer_unit.sv ***
// self-checking bench for the fp operand transfer unit
// assumes the partner model drives the instruction side
`timescale 1ns/100ps
`default_nettype none
module test_fp_operand_transfer_unit
  import fp_xfer_pkg::*;
;
  localparam logic [79:0] VA = 80'h4000_c90f_daa2_2168_c235;
  localparam logic [79:0] VB = 80'hbffe_8000_0000_0000_0001;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic ins_valid, ins_ready, ins_done, ins_reject, exc_invalid;
  logic exc_denormal, st_valid;
  logic carry_status_flag, zero_status_flag, parity_status_flag;
  logic [7:0] ins_opcode, ins_modrm;
  logic [79:0] ins_operand, st_data;
  logic [3:0] st_size;
  int fail_count, comparisons;

  fp_operand_transfer_unit u_fp_operand_transfer_unit (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .ins_valid, .ins_opcode, .ins_modrm, .ins_operand,
    .carry_status_flag, .zero_status_flag, .parity_status_flag, .ins_ready,
    .ins_done, .ins_reject, .exc_invalid, .exc_denormal, .st_valid,
    .st_data, .st_size);
  fp_xfer_partner u_partner (
    .pclk, .ins_ready, .ins_valid, .ins_opcode, .ins_modrm, .ins_operand,
    .carry_status_flag, .zero_status_flag, .parity_status_flag);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [79:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // pready, prdata and pslverr as sampled at this edge
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 16);
    if (!pready) begin
      fail_count++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0000_0000, r, e);
    check("prdata", {48'h0, exp}, {48'h0, r});
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  // flags in exp: reject, invalid, denormal, store valid
  task automatic run(input logic [7:0] op, rm, input logic [79:0] opd,
                     input logic [2:0] flg, input logic [3:0] exp);
    u_partner.issue(op, rm, opd, flg);
    check("done", 80'h1, {79'h0, ins_done});
    if (ins_done !== 1'b1) summarize();
    check("flags", {76'h0, exp},
          {76'h0, ins_reject, exc_invalid, exc_denormal, st_valid});
  endtask : run

  task automatic pop80(input logic [79:0] exp);
    run(OPC_DB, 8'h38, '0, 3'h0, 4'h1);
    check("st_data", exp, st_data);
    check("st_size", 80'ha, {76'h0, st_size});
  endtask : pop80

  task automatic push2();
    run(OPC_DB, 8'h28, VA, 3'h0, 4'h0);
    run(OPC_DB, 8'h28, VB, 3'h0, 4'h0);
  endtask : push2

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd(CTRL_OFS, 32'h0000_0003);
    rd(TAG_OFS, 32'h0000_0000);
    rd(FEATURE_OFS, 32'h0000_0001);
    apb(12'h010, 1'b0, 32'h0000_0000, r, e);
    check("pslverr", 80'h1, {79'h0, e});
  endtask : t_regs

  task automatic t_escape();
    logic [7:0] ops [4] = '{8'hd7, 8'he0, 8'h00, 8'hff};
    foreach (ops[k])
      run(ops[k], 8'h28, VA, 3'h0, 4'h8);
    rd(TAG_OFS, 32'h0000_0000);
  endtask : t_escape

  task automatic t_classes();
    logic [79:0] bad [3] = '{80'h7fff_0000_0000_0000_0000,
      80'hffff_4000_0000_0000_0001, 80'h4000_0000_0000_0000_1000};
    foreach (bad[k]) begin
      run(OPC_DB, 8'h28, bad[k], 3'h0, 4'h4);
      pop80(EXT_INDEF);
    end
    run(OPC_DB, 8'h28, 80'h0000_8000_0000_0000_0001, 3'h0, 4'h2);
    pop80(80'h0001_8000_0000_0000_0001);
    run(OPC_DF, 8'h00, 80'h1234_0000_0000_0000_8000, 3'h0, 4'h0);
    pop80(80'hc00e_8000_0000_0000_0000);
    run(OPC_D9, 8'h00, 80'h3f80_0000, 3'h0, 4'h0);
    run(OPC_DD, 8'h18, '0, 3'h0, 4'h1);
    check("st_data", 80'h3ff0_0000_0000_0000, st_data);
    check("st_size", 80'h8, {76'h0, st_size});
    run(OPC_DB, 8'h28, 80'h7fff_8000_0000_0000_0000, 3'h0, 4'h0);
    run(OPC_DF, 8'h18, '0, 3'h0, 4'h5);
    check("st_data", 80'h8000, st_data);
    check("st_size", 80'h2, {76'h0, st_size});
    rd(STATUS_OFS, 32'h0000_0003);
    wr(CTRL_OFS, 32'h0000_0000);
    run(OPC_DB, 8'h28, bad[0], 3'h0, 4'h4);
    rd(TAG_OFS, 32'h0000_0000);
    wr(CTRL_OFS, 32'h0000_0003);
    wr(STATUS_OFS, 32'h0000_0003);
  endtask : t_classes

  task automatic t_moves();
    logic [2:0] tf [8] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0};
    logic [2:0] ff [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h4};
    logic [7:0] op;
    logic [7:0] rm;
    run(OPC_DB, 8'h28, VA, 3'h0, 4'h0);
    rd(STATUS_OFS, 32'h0000_0700);
    rd(TAG_OFS, 32'h0000_0080);
    run(OPC_D9, 8'hc0, '0, 3'h0, 4'h0);
    pop80(VA);
    pop80(VA);
    rd(TAG_OFS, 32'h0000_0000);
    push2();
    run(OPC_D9, 8'hc9, '0, 3'h0, 4'h0);
    pop80(VA);
    pop80(VB);
    push2();
    run(OPC_DD, 8'hd9, '0, 3'h0, 4'h0);
    pop80(VB);
    for (int k = 0; k < 8; k++) begin
      op = (k < 4) ? OPC_DA : OPC_DB;
      rm = 8'hc1 + 8'(8 * (k % 4));
      push2();
      run(op, rm, '0, ff[k], 4'h0);
      pop80(VB);
      run(OPC_DB, 8'h28, VB, 3'h0, 4'h0);
      run(op, rm, '0, tf[k], 4'h0);
      pop80(VA);
      pop80(VA);
    end
  endtask : t_moves

  initial begin
    fail_count = 0;
    comparisons = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_escape();
    t_classes();
    t_moves();
    summarize();
  end
endmodule : test_fp_operand_transfer_unit
`default_nettype wire
